/* File: rtl/rsf_pkg.sv */
// rsf_pkg: constants shared by the regulator safety status flag bank.
// assumes a serial front end that decodes read commands into strobes.
package rsf_pkg;

  // ==========================================================
  // register geometry
  localparam int unsigned REG_W = 8;

  // ==========================================================
  // read command codes, one per status register
  typedef enum logic [1:0] {
    RSF_CMD_PRI_FAULT = 2'h0,
    RSF_CMD_PRI_THERM = 2'h1,
    RSF_CMD_CORE_FAULT = 2'h2,
    RSF_CMD_CORE_THERM = 2'h3
  } rsf_cmd_t;

  // ==========================================================
  // settable flag masks, reserved bits read as zero
  localparam logic [7:0] PRI_FAULT_MASK = 8'h3F;
  localparam logic [7:0] PRI_THERM_MASK = 8'h03;
  localparam logic [7:0] CORE_FAULT_MASK = 8'h1F;
  localparam logic [7:0] CORE_THERM_MASK = 8'h03;

  // ==========================================================
  // reset values
  localparam logic [7:0] STAT_RESET = 8'h00;

  // ==========================================================
  // field positions
  localparam int unsigned FLT_SHORT_BIT = 0;
  localparam int unsigned FLT_OVERLOAD_BIT = 1;
  localparam int unsigned FLT_SINK_BIT = 2;
  localparam int unsigned FLT_OVP_BIT = 3;
  localparam int unsigned FLT_GND_LOSS_BIT = 4;
  localparam int unsigned FLT_EOVP_BIT = 5;
  localparam int unsigned THM_WARN_BIT = 0;
  localparam int unsigned THM_SHDN_BIT = 1;

endpackage : rsf_pkg

/* File: rtl/rsf_status_bank.sv */
// rsf_status_bank: four read-clear safety status registers for the
// primary and core buck regulators.
// assumes monitor condition inputs are synchronous levels, and that
// the serial front end gives a one-cycle read strobe with a command.
// power_on_reset_n clears synchronously and is not gated by clk_en;
// rst is the asynchronous reset.
//
// Function
// - set flag holds until its register read
// - read clears only flags whose condition ended
// - power-on reset initialises; else reads only
// - registers read-only, one command each
// - primary fault bit5 extreme overvoltage, 7-6 zero
// - primary fault bit4 ground loss
// - primary fault bit3 overvoltage protection
// - primary fault bit2 low-side sink limit
// - primary fault bit1 overload
// - primary fault bit0 short to ground
// - primary thermal bit1 shutdown, 7-2 zero
// - primary thermal bit0 warning
// - core fault bit4 ground loss, 7-5 zero
// - core fault bit3 overvoltage protection
// - core fault bit2 low-side sink limit
// - core fault bit1 overload
// - core fault bit0 short to ground
// - core thermal bit1 shutdown, 7-2 zero
// - core thermal bit0 warning
`timescale 1ns/1ps

module rsf_status_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic power_on_reset_n,
  input wire logic primary_extreme_overvoltage,
  input wire logic primary_ground_loss,
  input wire logic primary_overvoltage,
  input wire logic primary_low_side_sink_limit,
  input wire logic primary_overload,
  input wire logic primary_short_to_ground,
  input wire logic primary_thermal_shutdown,
  input wire logic primary_thermal_warning,
  input wire logic core_ground_loss,
  input wire logic core_overvoltage,
  input wire logic core_low_side_sink_limit,
  input wire logic core_overload,
  input wire logic core_short_to_ground,
  input wire logic core_thermal_shutdown,
  input wire logic core_thermal_warning,
  input wire logic rd_strobe,
  input wire logic [1:0] rd_cmd,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] primary_regulator_fault_status,
  output logic [7:0] primary_regulator_thermal_status,
  output logic [7:0] core_regulator_fault_status,
  output logic [7:0] core_regulator_thermal_status
);

  // ==========================================================
  // condition vectors
  logic [7:0] pri_fault_cond;
  logic [7:0] pri_therm_cond;
  logic [7:0] core_fault_cond;
  logic [7:0] core_therm_cond;

  always_comb begin
    pri_fault_cond = rsf_pkg::STAT_RESET;
    pri_fault_cond[rsf_pkg::FLT_EOVP_BIT] = primary_extreme_overvoltage;
    pri_fault_cond[rsf_pkg::FLT_GND_LOSS_BIT] = primary_ground_loss;
    pri_fault_cond[rsf_pkg::FLT_OVP_BIT] = primary_overvoltage;
    pri_fault_cond[rsf_pkg::FLT_SINK_BIT] = primary_low_side_sink_limit;
    pri_fault_cond[rsf_pkg::FLT_OVERLOAD_BIT] = primary_overload;
    pri_fault_cond[rsf_pkg::FLT_SHORT_BIT] = primary_short_to_ground;
  end

  // primary thermal conditions
  always_comb begin
    pri_therm_cond = rsf_pkg::STAT_RESET;
    pri_therm_cond[rsf_pkg::THM_SHDN_BIT] = primary_thermal_shutdown;
    pri_therm_cond[rsf_pkg::THM_WARN_BIT] = primary_thermal_warning;
  end

  // core fault conditions
  always_comb begin
    core_fault_cond = rsf_pkg::STAT_RESET;
    core_fault_cond[rsf_pkg::FLT_GND_LOSS_BIT] = core_ground_loss;
    core_fault_cond[rsf_pkg::FLT_OVP_BIT] = core_overvoltage;
    core_fault_cond[rsf_pkg::FLT_SINK_BIT] = core_low_side_sink_limit;
    core_fault_cond[rsf_pkg::FLT_OVERLOAD_BIT] = core_overload;
    core_fault_cond[rsf_pkg::FLT_SHORT_BIT] = core_short_to_ground;
  end

  // core thermal conditions
  always_comb begin
    core_therm_cond = rsf_pkg::STAT_RESET;
    core_therm_cond[rsf_pkg::THM_SHDN_BIT] = core_thermal_shutdown;
    core_therm_cond[rsf_pkg::THM_WARN_BIT] = core_thermal_warning;
  end

  // ==========================================================
  // flag update
  // a read clears only bits whose condition is gone this cycle, so a
  // condition that is still present, or that returns during the read,
  // survives
  function automatic logic [7:0] flag_update(
    input logic [7:0] cur,
    input logic [7:0] cond,
    input logic [7:0] mask,
    input logic rd
  );
    logic [7:0] kept;
    kept = rd ? (cur & cond) : cur;
    return (kept | cond) & mask;
  endfunction : flag_update

  // ==========================================================
  // read command decode
  // strobe and code must agree, so the idle code left on the bus
  // between reads never clears a register
  function automatic logic rd_hit(
    input logic strobe,
    input logic [1:0] cmd,
    input rsf_pkg::rsf_cmd_t code
  );
    return strobe && (cmd == code);
  endfunction : rd_hit

  logic rd_pf;
  logic rd_pt;
  logic rd_cf;
  logic rd_ct;

  always_comb begin
    rd_pf = rd_hit(rd_strobe, rd_cmd, rsf_pkg::RSF_CMD_PRI_FAULT);
    rd_pt = rd_hit(rd_strobe, rd_cmd, rsf_pkg::RSF_CMD_PRI_THERM);
    rd_cf = rd_hit(rd_strobe, rd_cmd, rsf_pkg::RSF_CMD_CORE_FAULT);
    rd_ct = rd_hit(rd_strobe, rd_cmd, rsf_pkg::RSF_CMD_CORE_THERM);
  end

  // ==========================================================
  // primary fault flags
  logic [7:0] pri_fault_reg;
  logic [7:0] pri_fault_next;

  always_comb begin
    pri_fault_next = flag_update(pri_fault_reg, pri_fault_cond,
                                 rsf_pkg::PRI_FAULT_MASK, rd_pf);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pri_fault_reg <= rsf_pkg::STAT_RESET;
    end else if (!power_on_reset_n) begin
      pri_fault_reg <= rsf_pkg::STAT_RESET;
    end else if (clk_en) begin
      pri_fault_reg <= pri_fault_next;
    end
  end

  // ==========================================================
  // primary thermal flags
  logic [7:0] pri_therm_reg;
  logic [7:0] pri_therm_next;

  always_comb begin
    pri_therm_next = flag_update(pri_therm_reg, pri_therm_cond,
                                 rsf_pkg::PRI_THERM_MASK, rd_pt);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pri_therm_reg <= rsf_pkg::STAT_RESET;
    end else if (!power_on_reset_n) begin
      pri_therm_reg <= rsf_pkg::STAT_RESET;
    end else if (clk_en) begin
      pri_therm_reg <= pri_therm_next;
    end
  end

  // ==========================================================
  // core fault flags
  logic [7:0] core_fault_reg;
  logic [7:0] core_fault_next;

  always_comb begin
    core_fault_next = flag_update(core_fault_reg, core_fault_cond,
                                  rsf_pkg::CORE_FAULT_MASK, rd_cf);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_fault_reg <= rsf_pkg::STAT_RESET;
    end else if (!power_on_reset_n) begin
      core_fault_reg <= rsf_pkg::STAT_RESET;
    end else if (clk_en) begin
      core_fault_reg <= core_fault_next;
    end
  end

  // ==========================================================
  // core thermal flags
  logic [7:0] core_therm_reg;
  logic [7:0] core_therm_next;

  always_comb begin
    core_therm_next = flag_update(core_therm_reg, core_therm_cond,
                                  rsf_pkg::CORE_THERM_MASK, rd_ct);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_therm_reg <= rsf_pkg::STAT_RESET;
    end else if (!power_on_reset_n) begin
      core_therm_reg <= rsf_pkg::STAT_RESET;
    end else if (clk_en) begin
      core_therm_reg <= core_therm_next;
    end
  end

  // ==========================================================
  // read port
  // the word returned is the value before the clear, so only the
  // second read of a register shows that its condition has gone
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;

  // returned data is pre-clear value, reread confirms
  always_comb begin
    rd_valid_next = rd_strobe;
    rd_data_next = rd_data_reg;
    if (rd_strobe) begin
      unique case (rd_cmd)
        rsf_pkg::RSF_CMD_PRI_FAULT: rd_data_next = pri_fault_reg;
        rsf_pkg::RSF_CMD_PRI_THERM: rd_data_next = pri_therm_reg;
        rsf_pkg::RSF_CMD_CORE_FAULT: rd_data_next = core_fault_reg;
        rsf_pkg::RSF_CMD_CORE_THERM: rd_data_next = core_therm_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= rsf_pkg::STAT_RESET;
      rd_valid_reg <= 1'h0;
    end else if (!power_on_reset_n) begin
      rd_data_reg <= rsf_pkg::STAT_RESET;
      rd_valid_reg <= 1'h0;
    end else if (clk_en) begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // ==========================================================
  // outputs
  // every output comes straight from a flop
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign primary_regulator_fault_status = pri_fault_reg;
  assign primary_regulator_thermal_status = pri_therm_reg;
  assign core_regulator_fault_status = core_fault_reg;
  assign core_regulator_thermal_status = core_therm_reg;

endmodule : rsf_status_bank

/* File: verification/rsf_status_bank_sva.sv */
// status bank checker: read-clear, reserved and reset relations
// assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps
module rsf_status_bank_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic power_on_reset_n,
  input wire logic primary_short_to_ground,
  input wire logic rd_strobe,
  input wire logic [1:0] rd_cmd,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] primary_regulator_fault_status,
  input wire logic [7:0] primary_regulator_thermal_status,
  input wire logic [7:0] core_regulator_fault_status,
  input wire logic [7:0] core_regulator_thermal_status);
  wire go = clk_en && power_on_reset_n, rd = go && rd_strobe;
  wire [7:0] pf = primary_regulator_fault_status;
  wire [7:0] pt = primary_regulator_thermal_status;
  wire [7:0] cf = core_regulator_fault_status;
  wire [7:0] ct = core_regulator_thermal_status;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_resv; !(pf & 8'hC0) && !(pt & 8'hFC); endproperty
  property p_set; go && primary_short_to_ground |=> pf[0]; endproperty
  property p_hold; go && !rd_strobe |=> &(pf | ~$past(pf)); endproperty
  property p_clr; rd && !rd_cmd |=> pf[0] == $past(primary_short_to_ground);
  endproperty
  property p_rdv; rd |=> rd_valid; endproperty
  property p_nov; go && !rd_strobe |=> !rd_valid; endproperty
  property p_rdd; rd && rd_cmd == 2'h1 |=> rd_data == $past(pt); endproperty
  property p_por; !power_on_reset_n |=>
    !{pf, pt, cf, ct, rd_data, rd_valid}; endproperty
  property p_cresv; !(cf & 8'hE0) && !(ct & 8'hFC); endproperty
  property p_frz; !clk_en && power_on_reset_n |=>
    $stable({pf, pt, cf, ct, rd_data, rd_valid}); endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  a_set: assert property (p_set) else $error("no set");
  a_hold: assert property (p_hold) else $error("flag lost");
  a_clr: assert property (p_clr) else $error("bad clear");
  a_rdv: assert property (p_rdv) else $error("no valid");
  a_nov: assert property (p_nov) else $error("stray valid");
  a_rdd: assert property (p_rdd) else $error("bad data");
  a_por: assert property (p_por) else $error("no clear");
  a_cresv: assert property (p_cresv) else $error("core reserved");
  a_frz: assert property (p_frz) else $error("frozen state moved");
  c_rd: cover property (rd);
  c_clr: cover property (rd && !rd_cmd && primary_short_to_ground);
  c_por: cover property (!power_on_reset_n);
  c_frz: cover property (!clk_en && power_on_reset_n);
endmodule : rsf_status_bank_sva
bind rsf_status_bank rsf_status_bank_sva u_sva (.mclk(mclk), .rst(rst),
  .clk_en(clk_en), .power_on_reset_n(power_on_reset_n),
  .primary_short_to_ground(primary_short_to_ground),
  .rd_strobe(rd_strobe), .rd_cmd(rd_cmd), .rd_data(rd_data),
  .rd_valid(rd_valid),
  .primary_regulator_fault_status(primary_regulator_fault_status),
  .primary_regulator_thermal_status(primary_regulator_thermal_status),
  .core_regulator_fault_status(core_regulator_fault_status),
  .core_regulator_thermal_status(core_regulator_thermal_status));

/* File: verification/rsf_mcu_model.sv */
// controller model issuing one status read at a time
// assumes the bank answers at the taking edge, sampled 1 ns after it
`timescale 1ns/1ps
module rsf_mcu_model (
  input wire logic mclk,
  output logic rd_strobe,
  output logic [1:0] rd_cmd,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid);
  initial {rd_strobe, rd_cmd} = 3'h0;
  // dedicated command, held to the edge
  task automatic rd(input logic [1:0] c, output logic [7:0] d,
    output logic v);
    @(posedge mclk);
    #1 {rd_strobe, rd_cmd} = {1'b1, c};
    @(posedge mclk);
    #1 {v, d} = {rd_valid, rd_data};
    // idle code inverted so a stale command never matches
    {rd_strobe, rd_cmd} = {1'b0, ~c};
  endtask : rd
endmodule : rsf_mcu_model

/* File: verification/test_regulator_safety_status_flags.sv */
// bench: flag patterns read twice per register, then a live fault
// assumes the controller model and the bound checker
`timescale 1ns/1ps
module test_regulator_safety_status_flags;
  logic mclk = 1'b0, rst, clk_en, power_on_reset_n, rd_strobe, rd_valid, v;
  logic [1:0] rd_cmd;
  logic [7:0] rd_data, d;
  logic [14:0] c;
  wire [31:0] st;
  int errors = 0, n_checks = 0;
  logic [46:0] rows [4] = '{{15'h0000, 32'h00000000},
    {15'h5555, 32'h2A021501}, {15'h2AAA, 32'h15010A02},
    {15'h7FFF, 32'h3F031F03}};
  rsf_status_bank DUT (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .power_on_reset_n(power_on_reset_n),
    .rd_strobe(rd_strobe), .rd_cmd(rd_cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .primary_extreme_overvoltage(c[14]),
    .primary_ground_loss(c[13]), .primary_overvoltage(c[12]),
    .primary_low_side_sink_limit(c[11]), .primary_overload(c[10]),
    .primary_short_to_ground(c[9]), .primary_thermal_shutdown(c[8]),
    .primary_thermal_warning(c[7]), .core_ground_loss(c[6]),
    .core_overvoltage(c[5]), .core_low_side_sink_limit(c[4]),
    .core_overload(c[3]), .core_short_to_ground(c[2]),
    .core_thermal_shutdown(c[1]), .core_thermal_warning(c[0]),
    .primary_regulator_fault_status(st[31:24]),
    .primary_regulator_thermal_status(st[23:16]),
    .core_regulator_fault_status(st[15:8]),
    .core_regulator_thermal_status(st[7:0]));
  rsf_mcu_model mcu (.mclk(mclk), .rd_strobe(rd_strobe), .rd_cmd(rd_cmd),
    .rd_data(rd_data), .rd_valid(rd_valid));
  initial forever #50 mclk = ~mclk;
  // watchdog: about ten times the planned run of some hundred cycles
  initial #100000 results(1);
  task automatic rdc(input logic [1:0] k, input logic [7:0] e);
    mcu.rd(k, d, v);
    n_checks++;
    if ({v, d} !== {1'b1, e}) begin
      errors++;
      $display("Error %0t: read %0d got %h", $time, k, d);
    end
  endtask : rdc
  task automatic chk(input logic [31:0] e);
    n_checks++;
    if (st !== e) begin
      errors++;
      $display("Error %0t: status %h expected %h", $time, st, e);
    end
  endtask : chk
  task automatic results(input int miss);
    errors += miss;
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    {rst, clk_en, power_on_reset_n, c} = {3'h6, 15'h0000};
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    // power-on reset low for the first edge
    foreach (rows[i]) begin
      @(posedge mclk);
      #1 {power_on_reset_n, c} = {1'b1, rows[i][46:32]};
      @(posedge mclk);
      #1 c = 15'h0000;
      chk(rows[i][31:0]);
      for (int k = 0; k < 4; k++) begin
        rdc(2'(k), rows[i][31 - 8 * k -: 8]);
        rdc(2'(k), 8'h00);
      end
      chk(32'h00000000);
    end
    c[9] = 1'b1;
    rdc(2'h0, 8'h01);
    rdc(2'h0, 8'h01);
    c[9] = 1'b0;
    rdc(2'h0, 8'h01);
    rdc(2'h0, 8'h00);
    // clock enable low: no flag set and no read taken
    @(posedge mclk);
    #1 {clk_en, c[0]} = 2'h1;
    mcu.rd(2'h3, d, v);
    chk(32'h00000000);
    n_checks++;
    if (v !== 1'b0) begin
      errors++;
      $display("Error %0t: read taken while frozen", $time);
    end
    clk_en = 1'b1;
    @(posedge mclk);
    #1 c[0] = 1'b0;
    rdc(2'h3, 8'h01);
    rdc(2'h3, 8'h00);
    // mid-run reset clears every flag at once
    c = 15'h7FFF;
    @(posedge mclk);
    #1 chk(32'h3F031F03);
    {rst, c} = {1'b1, 15'h0000};
    #1 chk(32'h00000000);
    @(posedge mclk);
    #1 rst = 1'b0;
    rdc(2'h2, 8'h00);
    results(0);
  end
endmodule : test_regulator_safety_status_flags
